/* File: logic/root_port_error_status_log.sv */
// root port error message status and error source id registers
//
// How it works
// - correctable error with first flag clear sets first-correctable bit 0
// - requestor id of first correctable error lands in source id 15:0
// - fatal or non-fatal error with first flag clear sets bit 2
// - requestor id of first uncorrectable error lands in source id 31:16
// - correctable error while first flag set sets multiple-correctable bit 1
// - uncorrectable error while first flag set sets multiple-uncorrectable bit 3
// - two first errors in one clock set only the first flag
// - while first flag is set later ids are dropped, log unchanged
// - bit 4 records whether the first uncorrectable error was fatal
// - bit 6 sets whenever a fatal error message is seen
// - bit 5 sets whenever a non-fatal error message is seen
// - bits 6, 4 and 2 form the fatal escalation clear condition
// - bits 5, 4 and 2 form the non-fatal escalation clear condition
// - status flags clear only where software writes a one
// - flags and ids survive system reset, only power-on clears them
// - link error wins over internal error in the same clock
// - bits 31:27 read back the msi message number offset
`timescale 1ns/1ps
`default_nettype none
module root_port_error_status_log (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // error message received from the link
  input wire logic link_err_valid,
  input wire logic [1:0] link_err_sev,
  input wire logic [root_err_pkg::RID_W-1:0] link_err_rid,
  // internally detected error
  input wire logic int_err_valid,
  input wire logic [1:0] int_err_sev,
  input wire logic [root_err_pkg::RID_W-1:0] int_err_rid,
  // msi vector offset from the interrupt logic
  input wire logic [root_err_pkg::MSI_W-1:0] msi_msg_offset,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_ff,
  output logic cfg_rvalid_ff,
  // escalation clear conditions
  output logic fatal_esc_clr_ff,
  output logic nonfatal_esc_clr_ff
);

  function automatic logic sev_hit(
    input logic valid,
    input logic [1:0] sev,
    input logic [1:0] want
  );
    return valid && (sev == want);
  endfunction

  logic link_corr;
  logic link_nonfatal;
  logic link_fatal;
  logic int_corr;
  logic int_nonfatal;
  logic int_fatal;
  logic link_unc;
  logic int_unc;
  logic sts_wr;
  logic [root_err_pkg::W1C_W-1:0] w1c;
  logic first_corr;
  logic multi_corr;
  logic first_unc;
  logic multi_unc;
  logic unc_capture;
  logic [root_err_pkg::RID_W-1:0] corr_rid;
  logic [root_err_pkg::RID_W-1:0] unc_rid;
  logic first_fatal_ff;
  logic fatal_det_ff;
  logic nonfatal_det_ff;
  logic nxt_fatal_esc_clr;
  logic nxt_nonfatal_esc_clr;
  logic [31:0] sts_word;
  logic [31:0] sid_word;
  logic [31:0] nxt_rdata;

  // event decode per class
  assign link_corr = sev_hit(link_err_valid, link_err_sev, root_err_pkg::SEV_CORR);
  assign link_nonfatal = sev_hit(link_err_valid, link_err_sev, root_err_pkg::SEV_NONFATAL);
  assign link_fatal = sev_hit(link_err_valid, link_err_sev, root_err_pkg::SEV_FATAL);
  assign int_corr = sev_hit(int_err_valid, int_err_sev, root_err_pkg::SEV_CORR);
  assign int_nonfatal = sev_hit(int_err_valid, int_err_sev, root_err_pkg::SEV_NONFATAL);
  assign int_fatal = sev_hit(int_err_valid, int_err_sev, root_err_pkg::SEV_FATAL);
  assign link_unc = link_nonfatal | link_fatal;
  assign int_unc = int_nonfatal | int_fatal;

  // only byte 0 holds clearable bits; zeros clear nothing
  assign sts_wr = cfg_wr && (cfg_addr == root_err_pkg::ROOT_STS_OFS) && cfg_be[0];
  assign w1c = sts_wr ? cfg_wdata[root_err_pkg::W1C_W-1:0] : '0;

  error_class_log u_corr (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .link_hit(link_corr),
    .link_rid(link_err_rid),
    .int_hit(int_corr),
    .int_rid(int_err_rid),
    .clr_first(w1c[root_err_pkg::FIRST_CORR_BIT]),
    .clr_multi(w1c[root_err_pkg::MULTI_CORR_BIT]),
    .first_ff(first_corr),
    .multi_ff(multi_corr),
    .rid_ff(corr_rid),
    .capture()
  );

  error_class_log u_unc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .link_hit(link_unc),
    .link_rid(link_err_rid),
    .int_hit(int_unc),
    .int_rid(int_err_rid),
    .clr_first(w1c[root_err_pkg::FIRST_UNC_BIT]),
    .clr_multi(w1c[root_err_pkg::MULTI_UNC_BIT]),
    .first_ff(first_unc),
    .multi_ff(multi_unc),
    .rid_ff(unc_rid),
    .capture(unc_capture)
  );

  // kind of the first uncorrectable error, link first
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      first_fatal_ff <= 1'b0;
    else if (unc_capture)
      first_fatal_ff <= link_unc ? link_fatal : int_fatal;
    else if (w1c[root_err_pkg::FIRST_FATAL_BIT])
      first_fatal_ff <= 1'b0;
  end

  // fatal detected, set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      fatal_det_ff <= 1'b0;
    else if (link_fatal || int_fatal)
      fatal_det_ff <= 1'b1;
    else if (w1c[root_err_pkg::FATAL_DET_BIT])
      fatal_det_ff <= 1'b0;
  end

  // non-fatal detected, set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      nonfatal_det_ff <= 1'b0;
    else if (link_nonfatal || int_nonfatal)
      nonfatal_det_ff <= 1'b1;
    else if (w1c[root_err_pkg::NONFATAL_DET_BIT])
      nonfatal_det_ff <= 1'b0;
  end

  // fatal escalation may clear once nothing fatal is logged
  assign nxt_fatal_esc_clr = ~fatal_det_ff & ~(first_unc & first_fatal_ff);
  // non-fatal escalation may clear once nothing non-fatal is logged
  assign nxt_nonfatal_esc_clr = ~nonfatal_det_ff & ~(first_unc & ~first_fatal_ff);

  // registered so downstream escalation sees a glitch-free level
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fatal_esc_clr_ff <= 1'b1;
      nonfatal_esc_clr_ff <= 1'b1;
    end
    else
    begin
      fatal_esc_clr_ff <= nxt_fatal_esc_clr;
      nonfatal_esc_clr_ff <= nxt_nonfatal_esc_clr;
    end
  end

  // status word; reserved bits read zero
  always_comb
  begin
    sts_word = root_err_pkg::ROOT_STS_RST;
    sts_word[root_err_pkg::MSI_LSB +: root_err_pkg::MSI_W] = msi_msg_offset;
    sts_word[root_err_pkg::FATAL_DET_BIT] = fatal_det_ff;
    sts_word[root_err_pkg::NONFATAL_DET_BIT] = nonfatal_det_ff;
    sts_word[root_err_pkg::FIRST_FATAL_BIT] = first_fatal_ff;
    sts_word[root_err_pkg::MULTI_UNC_BIT] = multi_unc;
    sts_word[root_err_pkg::FIRST_UNC_BIT] = first_unc;
    sts_word[root_err_pkg::MULTI_CORR_BIT] = multi_corr;
    sts_word[root_err_pkg::FIRST_CORR_BIT] = first_corr;
  end

  always_comb
  begin
    sid_word = root_err_pkg::SRC_ID_RST;
    sid_word[root_err_pkg::UNC_SID_LSB +: root_err_pkg::RID_W] = unc_rid;
    sid_word[root_err_pkg::CORR_SID_LSB +: root_err_pkg::RID_W] = corr_rid;
  end

  // unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    if (cfg_addr == root_err_pkg::ROOT_STS_OFS)
      nxt_rdata = sts_word;
    else if (cfg_addr == root_err_pkg::SRC_ID_OFS)
      nxt_rdata = sid_word;
  end

  // read data holds until the next read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_rdata_ff <= 32'h00000000;
    else if (cfg_rd)
      cfg_rdata_ff <= nxt_rdata;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_rvalid_ff <= 1'b0;
    else
      cfg_rvalid_ff <= cfg_rd;
  end

  // reset_n is the power-on reset; no system reset reaches this state

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_corr_first;
    (link_corr || int_corr) && !first_corr;
  endsequence

  sequence s_unc_first;
    (link_unc || int_unc) && !first_unc;
  endsequence

  sequence s_sts_read;
    cfg_rd && (cfg_addr == root_err_pkg::ROOT_STS_OFS);
  endsequence

  // a first error never sets multi, even when a later error follows at once
  property p_first_corr;
    s_corr_first ##0 !multi_corr |=> first_corr && !multi_corr;
  endproperty
  a_first_corr: assert property (p_first_corr)
    else $error("first correctable flag not held after first error");

  property p_corr_rid;
    link_corr && !first_corr |=> corr_rid == $past(link_err_rid);
  endproperty
  a_corr_rid: assert property (p_corr_rid)
    else $error("correctable source id not captured");

  property p_first_unc;
    s_unc_first |=> first_unc;
  endproperty
  a_first_unc: assert property (p_first_unc)
    else $error("first uncorrectable flag not set");

  property p_unc_rid;
    int_unc && !link_unc && !first_unc |=> unc_rid == $past(int_err_rid);
  endproperty
  a_unc_rid: assert property (p_unc_rid)
    else $error("uncorrectable source id not captured");

  property p_multi_corr;
    (link_corr || int_corr) && first_corr |=> multi_corr;
  endproperty
  a_multi_corr: assert property (p_multi_corr)
    else $error("multiple correctable flag not set");

  property p_multi_unc;
    (link_unc || int_unc) && first_unc |=> multi_unc;
  endproperty
  a_multi_unc: assert property (p_multi_unc)
    else $error("multiple uncorrectable flag not set");

  property p_same_clock;
    link_unc && int_unc && !first_unc && !multi_unc |=> !multi_unc;
  endproperty
  a_same_clock: assert property (p_same_clock)
    else $error("same-clock first errors set the multiple flag");

  property p_rid_hold;
    first_corr && first_unc |=> $stable(corr_rid) && $stable(unc_rid);
  endproperty
  a_rid_hold: assert property (p_rid_hold)
    else $error("logged source id changed while first flag set");

  property p_fatal_kind;
    s_unc_first ##0 link_unc |=> first_fatal_ff == $past(link_fatal);
  endproperty
  a_fatal_kind: assert property (p_fatal_kind)
    else $error("first fatal flag does not match first error");

  property p_fatal_det;
    link_fatal |=> fatal_det_ff ##1 !fatal_esc_clr_ff;
  endproperty
  a_fatal_det: assert property (p_fatal_det)
    else $error("fatal detected flag or escalation hold missing");

  property p_nonfatal_det;
    link_nonfatal |=> nonfatal_det_ff ##1 !nonfatal_esc_clr_ff;
  endproperty
  a_nonfatal_det: assert property (p_nonfatal_det)
    else $error("non-fatal detected flag or escalation hold missing");

  property p_fatal_esc;
    ##1 fatal_esc_clr_ff == !($past(fatal_det_ff) || ($past(first_unc) && $past(first_fatal_ff)));
  endproperty
  a_fatal_esc: assert property (p_fatal_esc)
    else $error("fatal escalation clear wrong");

  property p_nonfatal_esc;
    ##1 nonfatal_esc_clr_ff ==
      !($past(nonfatal_det_ff) || ($past(first_unc) && !$past(first_fatal_ff)));
  endproperty
  a_nonfatal_esc: assert property (p_nonfatal_esc)
    else $error("non-fatal escalation clear wrong");

  property p_w1c;
    sts_wr && cfg_wdata[root_err_pkg::FATAL_DET_BIT] && !link_fatal && !int_fatal
      |=> !fatal_det_ff;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("fatal detected flag not cleared by a one");

  property p_zero_write;
    cfg_wr && (cfg_wdata == 32'h00000000) && first_corr |=> first_corr;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("zero write cleared a status flag");

  property p_link_wins;
    link_corr && int_corr && !first_corr |=> corr_rid == $past(link_err_rid);
  endproperty
  a_link_wins: assert property (p_link_wins)
    else $error("internal id logged over link id");

  property p_msi;
    s_sts_read |=> cfg_rvalid_ff &&
      cfg_rdata_ff[root_err_pkg::MSI_LSB +: root_err_pkg::MSI_W] == $past(msi_msg_offset);
  endproperty
  a_msi: assert property (p_msi)
    else $error("msi offset not returned on status read");

endmodule
`default_nettype wire

/* File: include/root_err_pkg.sv */
// constants for the root port error status and source id logger
package root_err_pkg;
  // register offsets in configuration space
  localparam logic [11:0] ROOT_STS_OFS = 12'h130;
  localparam logic [11:0] SRC_ID_OFS = 12'h134;
  // reset values
  localparam logic [31:0] ROOT_STS_RST = 32'h00000000;
  localparam logic [31:0] SRC_ID_RST = 32'h00000000;
  localparam logic [15:0] RID_RST = 16'h0000;
  // root status field positions
  localparam int FIRST_CORR_BIT = 0;
  localparam int MULTI_CORR_BIT = 1;
  localparam int FIRST_UNC_BIT = 2;
  localparam int MULTI_UNC_BIT = 3;
  localparam int FIRST_FATAL_BIT = 4;
  localparam int NONFATAL_DET_BIT = 5;
  localparam int FATAL_DET_BIT = 6;
  localparam int MSI_LSB = 27;
  localparam int MSI_W = 5;
  localparam int W1C_W = 7;
  // source id field positions
  localparam int CORR_SID_LSB = 0;
  localparam int UNC_SID_LSB = 16;
  localparam int RID_W = 16;
  // severity encoding of an error event
  localparam logic [1:0] SEV_CORR = 2'h0;
  localparam logic [1:0] SEV_NONFATAL = 2'h1;
  localparam logic [1:0] SEV_FATAL = 2'h2;
endpackage

/* File: logic/error_class_log.sv */
// first/multiple flags and source id capture for one error class
`timescale 1ns/1ps
`default_nettype none
module error_class_log (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // error events of this class
  input wire logic link_hit,
  input wire logic [root_err_pkg::RID_W-1:0] link_rid,
  input wire logic int_hit,
  input wire logic [root_err_pkg::RID_W-1:0] int_rid,
  // write-one-to-clear strobes
  input wire logic clr_first,
  input wire logic clr_multi,
  // logged state
  output logic first_ff,
  output logic multi_ff,
  output logic [root_err_pkg::RID_W-1:0] rid_ff,
  output logic capture
);
  logic hit;

  assign hit = link_hit | int_hit;
  // a hit while the first flag is set is never a first error
  assign capture = hit & ~first_ff;

  // first flag: set wins over clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      first_ff <= 1'b0;
    else if (hit)
      first_ff <= 1'b1;
    else if (clr_first)
      first_ff <= 1'b0;
  end

  // only a hit in a later clock than the first sets multi
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      multi_ff <= 1'b0;
    else if (hit && first_ff)
      multi_ff <= 1'b1;
    else if (clr_multi)
      multi_ff <= 1'b0;
  end

  // link message wins over an internal error in the same clock
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rid_ff <= root_err_pkg::RID_RST;
    else if (capture)
      rid_ff <= link_hit ? link_rid : int_rid;
  end
endmodule
`default_nettype wire

/* File: verification/err_msg_source.sv */
// far-side model: a downstream device sending error messages over the link
`timescale 1ns/1ps
`default_nettype none
module err_msg_source (
  // clock
  input wire logic sys_clk,
  // error message toward the root port
  output logic link_err_valid,
  output logic [1:0] link_err_sev,
  output logic [root_err_pkg::RID_W-1:0] link_err_rid
);
  initial
  begin
    link_err_valid = 1'b0;
    link_err_sev = 2'h3;
    link_err_rid = 16'h0000;
  end
  // one message per call, one cycle long
  // fields are inverted outside the valid cycle so a late sample sees garbage
  task automatic send(input logic [1:0] sev, input logic [15:0] rid);
    @(negedge sys_clk);
    link_err_valid = 1'b1;
    link_err_sev = sev;
    link_err_rid = rid;
    @(negedge sys_clk);
    link_err_valid = 1'b0;
    link_err_sev = ~sev;
    link_err_rid = ~rid;
  endtask
endmodule
`default_nettype wire

/* File: verification/root_port_error_status_log_bench.sv */
// self-checking bench for the root port error status and source id logger
`timescale 1ns/1ps
`default_nettype none
module root_port_error_status_log_bench;
  logic sys_clk;
  logic reset_n;
  logic int_err_valid;
  logic [1:0] int_err_sev;
  logic [15:0] int_err_rid;
  logic [4:0] msi_msg_offset;
  logic cfg_wr;
  logic cfg_rd;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata;
  wire logic link_err_valid;
  wire logic [1:0] link_err_sev;
  wire logic [15:0] link_err_rid;
  wire logic [31:0] cfg_rdata_ff;
  wire logic cfg_rvalid_ff;
  wire logic fatal_esc_clr_ff;
  wire logic nonfatal_esc_clr_ff;
  int n_mismatch;
  int total_checks;

  always #2.5 sys_clk = ~sys_clk;

  err_msg_source far_end (
    .sys_clk(sys_clk),
    .link_err_valid(link_err_valid),
    .link_err_sev(link_err_sev),
    .link_err_rid(link_err_rid)
  );

  root_port_error_status_log DUT (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .link_err_valid(link_err_valid),
    .link_err_sev(link_err_sev),
    .link_err_rid(link_err_rid),
    .int_err_valid(int_err_valid),
    .int_err_sev(int_err_sev),
    .int_err_rid(int_err_rid),
    .msi_msg_offset(msi_msg_offset),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata_ff(cfg_rdata_ff),
    .cfg_rvalid_ff(cfg_rvalid_ff),
    .fatal_esc_clr_ff(fatal_esc_clr_ff),
    .nonfatal_esc_clr_ff(nonfatal_esc_clr_ff)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // read strobe one cycle, answer looked at one cycle later
  task automatic cfg_read(input logic [11:0] addr, input logic [31:0] exp);
    @(negedge sys_clk);
    cfg_rd = 1'b1;
    cfg_addr = addr;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    check("read valid", {31'h0, cfg_rvalid_ff}, 32'h1);
    check("read data", cfg_rdata_ff, exp);
  endtask

  task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  // status read with the live msi offset in the top field
  task automatic rd_sts(input logic [6:0] bits);
    cfg_read(root_err_pkg::ROOT_STS_OFS, {msi_msg_offset, 20'h00000, bits});
  endtask

  task automatic rd_sid(input logic [31:0] exp);
    cfg_read(root_err_pkg::SRC_ID_OFS, exp);
  endtask

  task automatic esc_chk(input logic [1:0] exp);
    check("escalation clear", {30'h0, fatal_esc_clr_ff, nonfatal_esc_clr_ff}, {30'h0, exp});
  endtask

  task automatic int_send(input logic [1:0] sev, input logic [15:0] rid);
    @(negedge sys_clk);
    int_err_valid = 1'b1;
    int_err_sev = sev;
    int_err_rid = rid;
    @(negedge sys_clk);
    int_err_valid = 1'b0;
    int_err_sev = ~sev;
    int_err_rid = ~rid;
  endtask

  task automatic power_on;
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    int_err_valid = 1'b0;
    int_err_sev = 2'h3;
    int_err_rid = 16'h0000;
    msi_msg_offset = 5'h15;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
    repeat (5) @(negedge sys_clk);
    reset_n = 1'b1;
    rd_sts(7'h00);
    rd_sid(32'h00000000);
    esc_chk(2'h3);
    far_end.send(root_err_pkg::SEV_CORR, 16'h1234);
    rd_sts(7'h01);
    rd_sid(32'h00001234);
    far_end.send(root_err_pkg::SEV_CORR, 16'h5678);
    rd_sts(7'h03);
    rd_sid(32'h00001234);
    // ignored writes: no byte enable, zero data, read-only id register
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h0, 32'h0000007f);
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'h00000000);
    cfg_write(root_err_pkg::SRC_ID_OFS, 4'hf, 32'hffffffff);
    rd_sts(7'h03);
    rd_sid(32'h00001234);
    cfg_read(12'h138, 32'h00000000);
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'h00000002);
    rd_sts(7'h01);
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'h00000001);
    rd_sts(7'h00);
    // link and internal correctable in one clock
    fork
      far_end.send(root_err_pkg::SEV_CORR, 16'haaaa);
      int_send(root_err_pkg::SEV_CORR, 16'hbbbb);
    join
    rd_sts(7'h01);
    rd_sid(32'h0000aaaa);
    far_end.send(root_err_pkg::SEV_FATAL, 16'hc001);
    rd_sts(7'h55);
    rd_sid(32'hc001aaaa);
    esc_chk(2'h1);
    int_send(root_err_pkg::SEV_NONFATAL, 16'hd002);
    rd_sts(7'h7d);
    rd_sid(32'hc001aaaa);
    esc_chk(2'h0);
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'hffffffff);
    rd_sts(7'h00);
    esc_chk(2'h3);
    far_end.send(root_err_pkg::SEV_NONFATAL, 16'he003);
    rd_sts(7'h24);
    rd_sid(32'he003aaaa);
    esc_chk(2'h2);
    // severity code 3 carries no error
    far_end.send(2'h3, 16'h7777);
    rd_sts(7'h24);
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'h0000007f);
    // link non-fatal beside internal fatal: link id and link severity win
    fork
      far_end.send(root_err_pkg::SEV_NONFATAL, 16'h0101);
      int_send(root_err_pkg::SEV_FATAL, 16'h0202);
    join
    rd_sts(7'h64);
    rd_sid(32'h0101aaaa);
    msi_msg_offset = 5'h0a;
    rd_sts(7'h64);
    // internal fatal alone as first uncorrectable error
    cfg_write(root_err_pkg::ROOT_STS_OFS, 4'h1, 32'h0000007f);
    int_send(root_err_pkg::SEV_FATAL, 16'h0303);
    rd_sts(7'h54);
    rd_sid(32'h0303aaaa);
    esc_chk(2'h1);
    power_on();
    rd_sts(7'h00);
    rd_sid(32'h00000000);
    esc_chk(2'h3);
    stop_test();
  end
endmodule
`default_nettype wire
